// File: hw/tissc_top.sv
// Behaviour
// - contact inputs qualify after 1600, 3200 or 400 us stable
// - other inputs qualify after 40, 350 or 5 us stable
// - six sensor kinds per input; kind picks the timing column
// - level changes only on full low or high threshold crossing
// - input B has its own kind and filter settings like A
// - mode 1 start A high stop B high; mode 2 A low, B low
// - mode 3 start A high stop A low; mode 4 the reverse
// - local mode runs only from front-panel buttons
// - no repeat: lower display shows set time or blank
// - repeat: show cycle total and number, delay count-down; no total if continuous
// - phase name shown briefly at start or periodically
// - clock to timer switch needs four confirm digits, then display mode
// - factory default restore needs confirm word
// - command clears grand-total runtime
// - second control output has the same settings as the first
// - program plus enter held together enters configuration menu
// - contact and open collector: open is high, closed is low
// - proximity: low current is high, high current is low
// - no start while set time is zero
`timescale 1ns/10ps
module tissc_top (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// comparator outputs: below low threshold, above high threshold, per input
	input wire logic [1:0] i_below_low,
	input wire logic [1:0] i_above_high,
	// per-input configuration, index 0 is A
	input wire tissc_pkg::tissc_incfg_t i_cfg_a,
	input wire tissc_pkg::tissc_incfg_t i_cfg_b,
	// run control
	input wire tissc_pkg::tissc_mode_t i_mode,
	input wire logic i_set_time_zero,
	input wire logic i_btn_start,
	input wire logic i_btn_stop,
	input wire logic i_btn_program,
	input wire logic i_btn_enter,
	input wire logic i_prompt_shown,
	// display configuration and phase status
	input wire tissc_pkg::tissc_dcfg_t i_dcfg,
	// confirmation digit entry
	input wire logic [3:0] i_digit,
	input wire logic i_digit_valid,
	input wire logic i_req_timer_func,
	input wire logic i_req_defaults,
	input wire logic i_req_clear_total,
	// second control output settings mirror the first
	input wire logic [7:0] i_out1_settings,
	// qualified levels and run state
	output logic [1:0] o_level,
	output logic o_running,
	output logic o_start_pulse,
	output logic o_stop_pulse,
	// display
	output tissc_pkg::tissc_disp_t o_disp,
	output logic o_show_total,
	output logic o_show_tag,
	// commands
	output logic o_timer_func,
	output logic o_display_mode,
	output logic o_restore_defaults,
	output logic o_clear_lifetime_runtime,
	output logic o_config_menu,
	output logic [7:0] o_out2_settings
);
	tissc_pkg::tissc_incfg_t cfg [2];
	logic [1:0] lvl_prev;
	logic [1:0] raw;
	logic [15:0] word;
	logic [1:0] digit_cnt;
	logic confirmed;
	logic start_ev;
	logic stop_ev;
	logic [3:0] tag_div;

	assign cfg[0] = i_cfg_a;
	assign cfg[1] = i_cfg_b;

	// filter per input; the comparator pair gives hysteresis for free
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_in
			logic [tissc_pkg::CNT_W-1:0] cnt;
			logic [tissc_pkg::CNT_W-1:0] width;
			logic cand;
			logic hold;
			// kind and filter strength pick the minimum width
			always_comb begin
				width = tissc_pkg::C_ON;
				if (cfg[g].kind == tissc_pkg::switch_closure_input) begin
					case (cfg[g].filt)
						tissc_pkg::filter_heavy: width = tissc_pkg::C_CH;
						tissc_pkg::filter_weak: width = tissc_pkg::C_CW;
						default: width = tissc_pkg::C_CN;
					endcase
				end else begin
					case (cfg[g].filt)
						tissc_pkg::filter_heavy: width = tissc_pkg::C_OH;
						tissc_pkg::filter_weak: width = tissc_pkg::C_OW;
						default: width = tissc_pkg::C_ON;
					endcase
				end
			end
			// between thresholds the last full crossing holds
			always_comb begin
				hold = cand;
				if (i_above_high[g]) begin
					hold = 1'b1;
				end else if (i_below_low[g]) begin
					hold = 1'b0;
				end
			end
			// counter reloads on candidate change
			always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					cand <= 1'b1;
					cnt <= '0;
					raw[g] <= 1'b1;
				end else begin
					cand <= hold;
					if (hold != cand) begin
						cnt <= tissc_pkg::CNT_ONE;
					end else if (cnt < width) begin
						cnt <= cnt + tissc_pkg::CNT_ONE;
					end else begin
						raw[g] <= cand;
					end
				end
			end
			// open contact or low current reads high: comparator senses that directly
			assign o_level[g] = raw[g];
		end
	endgenerate

	// edge detection of qualified levels
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lvl_prev <= tissc_pkg::LVL_IDLE;
		end else begin
			lvl_prev <= raw;
		end
	end

	// start and stop events by mode
	always_comb begin
		start_ev = 1'b0;
		stop_ev = 1'b0;
		case (i_mode)
			tissc_pkg::mode_ab_high: begin
				start_ev = raw[0] && !lvl_prev[0];
				stop_ev = raw[1] && !lvl_prev[1];
			end
			tissc_pkg::mode_ab_low: begin
				start_ev = !raw[0] && lvl_prev[0];
				stop_ev = !raw[1] && lvl_prev[1];
			end
			tissc_pkg::mode_a_high_low: begin
				start_ev = raw[0] && !lvl_prev[0];
				stop_ev = !raw[0] && lvl_prev[0];
			end
			tissc_pkg::mode_a_low_high: begin
				start_ev = !raw[0] && lvl_prev[0];
				stop_ev = raw[0] && !lvl_prev[0];
			end
			default: begin
				start_ev = i_btn_start;
				stop_ev = i_btn_stop;
			end
		endcase
	end

	// run state; stop beats start in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_running <= 1'b0;
		end else if (stop_ev) begin
			o_running <= 1'b0;
		end else if (start_ev && !i_set_time_zero) begin
			o_running <= 1'b1;
		end
	end

	// start pulse only for a start that is taken, so a refused one leaves no trace
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_start_pulse <= 1'b0;
		end else begin
			o_start_pulse <= start_ev && !stop_ev && !i_set_time_zero && !o_running;
		end
	end

	// stop pulse only when something was running, idle stops stay silent
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_stop_pulse <= 1'b0;
		end else begin
			o_stop_pulse <= stop_ev && o_running;
		end
	end

	// periodic tag divider; a few frames of slow blink would need the display clock
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tag_div <= '0;
		end else begin
			tag_div <= tag_div + tissc_pkg::TAG_STEP;
		end
	end

	// lower display content; a blanked readout wins over every repeat state
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_disp <= tissc_pkg::show_blank;
		end else if (!i_dcfg.readout_on) begin
			o_disp <= tissc_pkg::show_blank;
		end else if (!i_dcfg.repeat_on) begin
			o_disp <= tissc_pkg::show_set_time;
		end else if (i_dcfg.in_delay) begin
			o_disp <= tissc_pkg::show_delay;
		end else if (i_dcfg.continuous) begin
			o_disp <= tissc_pkg::show_cycles;
		end else begin
			o_disp <= tissc_pkg::show_cycles_total;
		end
	end

	// the cycle total is hidden during delay and when repetition never ends
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_show_total <= 1'b0;
		end else begin
			o_show_total <= i_dcfg.readout_on && i_dcfg.repeat_on &&
				!i_dcfg.in_delay && !i_dcfg.continuous;
		end
	end

	// phase name: brief at phase start, or blinking from the divider
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_show_tag <= 1'b0;
		end else if (i_dcfg.readout_on && i_dcfg.repeat_on) begin
			o_show_tag <= i_dcfg.periodic_tag ? tag_div[3] : i_dcfg.phase_start;
		end else begin
			o_show_tag <= 1'b0;
		end
	end

	// confirmation word shifts in digit by digit, most significant first
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			word <= '0;
		end else if (i_digit_valid) begin
			word <= {word[11:0], i_digit};
		end
	end

	// digit position; a timer function or defaults request restarts entry so stale digits cannot pair up
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			digit_cnt <= '0;
		end else if (i_digit_valid) begin
			digit_cnt <= digit_cnt + tissc_pkg::DIGIT_STEP;
		end else if (i_req_timer_func || i_req_defaults) begin
			digit_cnt <= '0;
		end
	end

	// confirmation holds until one request consumes it or the next digit clears it
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			confirmed <= 1'b0;
		end else if (i_digit_valid) begin
			confirmed <= (digit_cnt == tissc_pkg::DIGIT_LAST) &&
				({word[11:0], i_digit} == tissc_pkg::CONFIRM_WORD);
		end else if (i_req_timer_func || i_req_defaults) begin
			confirmed <= 1'b0; // one use per entry
		end
	end

	// instrument function; only the timer side lives in this block
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_timer_func <= 1'b1;
		end else if (i_req_timer_func && confirmed) begin
			o_timer_func <= 1'b1;
		end
	end

	// display mode left on menu entry, regained by a confirmed function switch
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_display_mode <= 1'b1;
		end else if (i_req_timer_func && confirmed) begin
			o_display_mode <= 1'b1;
		end else if (i_btn_program && i_btn_enter && i_prompt_shown) begin
			o_display_mode <= 1'b0;
		end
	end

	// configuration menu; a confirmed switch wins over buttons held meanwhile
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_config_menu <= 1'b0;
		end else if (i_req_timer_func && confirmed) begin
			o_config_menu <= 1'b0;
		end else if (i_btn_program && i_btn_enter && i_prompt_shown) begin
			o_config_menu <= 1'b1;
		end
	end

	// factory default restore, one pulse per confirmed request
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_restore_defaults <= 1'b0;
		end else begin
			o_restore_defaults <= i_req_defaults && confirmed;
		end
	end

	// grand total clear needs no confirmation
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_clear_lifetime_runtime <= 1'b0;
		end else begin
			o_clear_lifetime_runtime <= i_req_clear_total;
		end
	end

	// second output settings follow the first one cycle later
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out2_settings <= '0;
		end else begin
			o_out2_settings <= i_out1_settings;
		end
	end
endmodule : tissc_top

// File: hw/tissc_pkg.sv
package tissc_pkg;
	// sensor kinds
	typedef enum logic [2:0] {
		sink_transistor_input,
		low_swing_pulse_input,
		high_swing_pulse_input,
		magnetic_input,
		proximity_sensor_input,
		switch_closure_input
	} tissc_kind_t;
	// filter strength
	typedef enum logic [1:0] {
		filter_normal,
		filter_heavy,
		filter_weak
	} tissc_filt_t;
	// start/stop source
	typedef enum logic [2:0] {
		mode_ab_high,
		mode_ab_low,
		mode_a_high_low,
		mode_a_low_high,
		mode_local
	} tissc_mode_t;
	// lower display content
	typedef enum logic [2:0] {
		show_blank,
		show_set_time,
		show_cycles,
		show_cycles_total,
		show_delay
	} tissc_disp_t;
	// per-input configuration
	typedef struct packed {
		tissc_kind_t kind;
		tissc_filt_t filt;
	} tissc_incfg_t;
	// display configuration
	typedef struct packed {
		logic repeat_on;
		logic readout_on;
		logic periodic_tag;
		logic continuous;
		logic in_delay;
		logic phase_start;
	} tissc_dcfg_t;
	localparam int CLK_HZ = 20000000;
	localparam int T_CONTACT_NORM_US = 1600;
	localparam int T_CONTACT_HEAVY_US = 3200;
	localparam int T_CONTACT_WEAK_US = 400;
	localparam int T_OTHER_NORM_US = 40;
	localparam int T_OTHER_HEAVY_US = 350;
	localparam int T_OTHER_WEAK_US = 5;
	localparam int US_PER_S = 1000000;
	localparam int CNT_W = 17;
	localparam logic [CNT_W-1:0] C_CN = CNT_W'(T_CONTACT_NORM_US * (CLK_HZ / US_PER_S));
	localparam logic [CNT_W-1:0] C_CH = CNT_W'(T_CONTACT_HEAVY_US * (CLK_HZ / US_PER_S));
	localparam logic [CNT_W-1:0] C_CW = CNT_W'(T_CONTACT_WEAK_US * (CLK_HZ / US_PER_S));
	localparam logic [CNT_W-1:0] C_ON = CNT_W'(T_OTHER_NORM_US * (CLK_HZ / US_PER_S));
	localparam logic [CNT_W-1:0] C_OH = CNT_W'(T_OTHER_HEAVY_US * (CLK_HZ / US_PER_S));
	localparam logic [CNT_W-1:0] C_OW = CNT_W'(T_OTHER_WEAK_US * (CLK_HZ / US_PER_S));
	localparam logic [CNT_W-1:0] CNT_ONE = 17'h00001;
	localparam logic [15:0] CONFIRM_WORD = 16'h5E7A; // arbitrary confirmation code
	localparam logic [1:0] DIGIT_LAST = 2'h3;
	localparam logic [1:0] DIGIT_STEP = 2'h1;
	localparam logic [3:0] TAG_STEP = 4'h1;
	localparam logic [1:0] LVL_IDLE = 2'h3;
endpackage : tissc_pkg

// File: verification/tissc_properties.sv
`timescale 1ns/10ps
// watches run control, display and command outputs at the top ports
module tissc_checker (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// causes
	input wire tissc_pkg::tissc_mode_t i_mode,
	input wire logic i_set_time_zero,
	input wire logic i_btn_start,
	input wire logic i_btn_program,
	input wire logic i_btn_enter,
	input wire logic i_prompt_shown,
	input wire tissc_pkg::tissc_dcfg_t i_dcfg,
	input wire logic i_req_defaults,
	input wire logic [7:0] i_out1_settings,
	// effects
	input wire logic o_start_pulse,
	input wire logic o_stop_pulse,
	input wire tissc_pkg::tissc_disp_t o_disp,
	input wire logic o_restore_defaults,
	input wire logic o_config_menu,
	input wire logic [7:0] o_out2_settings
);
	// one domain, so clock and reset are given once
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	zero_set_time_a: assert property ($past(i_set_time_zero, 2) && $past(i_set_time_zero)
		|-> !o_start_pulse) else $error("start with zero set time");
	stop_wins_a: assert property (!(o_start_pulse && o_stop_pulse)) else $error("both pulses");
	start_single_a: assert property (o_start_pulse |=> !o_start_pulse) else $error("long start");
	local_quiet_a: assert property ($past(i_mode) == tissc_pkg::mode_local && !$past(i_btn_start)
		&& !$past(i_btn_start, 2) |-> !o_start_pulse) else $error("local start");
	out2_copy_a: assert property (o_out2_settings == $past(i_out1_settings))
		else $error("second output differs");
	menu_entry_a: assert property ($past(i_btn_program && i_btn_enter && i_prompt_shown)
		|-> o_config_menu) else $error("menu not entered");
	set_time_shown_a: assert property ($past(!i_dcfg.repeat_on && i_dcfg.readout_on)
		|-> o_disp == tissc_pkg::show_set_time) else $error("set time not shown");
	defaults_cause_a: assert property (o_restore_defaults |-> $past(i_req_defaults))
		else $error("stray restore");
	// main scenarios seen
	cover property (o_start_pulse);
	cover property (o_stop_pulse);
	cover property (o_restore_defaults);
endmodule : tissc_checker
bind tissc_top tissc_checker tissc_checker_i (.i_ref_clk, .i_rst_n, .i_mode, .i_set_time_zero,
	.i_btn_start, .i_btn_program, .i_btn_enter, .i_prompt_shown, .i_dcfg, .i_req_defaults,
	.i_out1_settings, .o_start_pulse, .o_stop_pulse, .o_disp, .o_restore_defaults,
	.o_config_menu, .o_out2_settings);

// File: verification/tissc_sensor.sv
`timescale 1ns/10ps
// one sensor seen through the two threshold comparators
module tissc_sensor (
	// clock
	input wire logic i_clk,
	// wanted level, and hold between thresholds
	input wire logic i_lvl,
	input wire logic i_mid,
	// comparator outputs
	output logic o_above,
	output logic o_below
);
	// in the mid band neither comparator fires, so the level must not move
	always_ff @(posedge i_clk) begin
		o_above <= i_lvl & ~i_mid;
		o_below <= ~i_lvl & ~i_mid;
	end
endmodule : tissc_sensor

// File: verification/tissc_bench.sv
`timescale 1ns/10ps
// sensor filtering, run modes, display and commands
module tissc_bench;
	`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
		$display("unexpected %0t %h %h", $time, a, e); end end
	int errors = 0;
	int checks = 0;
	logic i_ref_clk = 1'h0;
	logic i_rst_n = 1'h0;
	wire logic [1:0] i_below_low;
	wire logic [1:0] i_above_high;
	tissc_pkg::tissc_incfg_t i_cfg_a = {tissc_pkg::low_swing_pulse_input, tissc_pkg::filter_weak};
	tissc_pkg::tissc_incfg_t i_cfg_b = {tissc_pkg::switch_closure_input, tissc_pkg::filter_weak};
	tissc_pkg::tissc_mode_t i_mode = tissc_pkg::mode_local;
	tissc_pkg::tissc_dcfg_t i_dcfg = 6'h00;
	logic i_set_time_zero = 1'h1;
	logic i_btn_start = 1'h0, i_btn_stop = 1'h0, i_btn_program = 1'h0, i_btn_enter = 1'h0;
	logic i_prompt_shown = 1'h0, i_digit_valid = 1'h0;
	logic i_req_timer_func = 1'h0, i_req_defaults = 1'h0, i_req_clear_total = 1'h0;
	logic [3:0] i_digit = 4'h0;
	logic [7:0] i_out1_settings = 8'h00;
	logic [1:0] lvl = 2'h3, mid = 2'h0;
	logic [1:0] o_level;
	logic o_running, o_start_pulse, o_stop_pulse, o_show_total, o_show_tag, o_timer_func;
	logic o_display_mode, o_restore_defaults, o_clear_lifetime_runtime, o_config_menu;
	logic [7:0] o_out2_settings;
	tissc_pkg::tissc_disp_t o_disp;
	// prime, start, stop levels {b,a} for the four sensor modes
	logic [1:0] seq [4][3] = '{'{2'h0, 2'h1, 2'h3}, '{2'h3, 2'h2, 2'h0},
		'{2'h0, 2'h1, 2'h0}, '{2'h1, 2'h0, 2'h1}};
	tissc_top tissc_top_i (.*);
	tissc_sensor tissc_sensor_a_i (.i_clk(i_ref_clk), .i_lvl(lvl[0]), .i_mid(mid[0]),
		.o_above(i_above_high[0]), .o_below(i_below_low[0]));
	tissc_sensor tissc_sensor_b_i (.i_clk(i_ref_clk), .i_lvl(lvl[1]), .i_mid(mid[1]),
		.o_above(i_above_high[1]), .o_below(i_below_low[1]));
	initial forever #25 i_ref_clk = ~i_ref_clk;
	task tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : tick
	// set both sensors, wait, then settle before a check
	task sense(input logic [1:0] l, input int n);
		tick(1);
		lvl <= l;
		tick(n);
		@(negedge i_ref_clk);
	endtask : sense
	// digits go in most significant first
	task digits(input logic [15:0] w);
		for (int i = 3; i >= 0; i--) begin
			tick(1);
			i_digit <= w[i*4+:4];
			i_digit_valid <= 1'h1;
		end
		tick(1);
		i_digit_valid <= 1'h0;
	endtask : digits
	// one-cycle strobe of a command or button, k picks which
	task strobe(input int k, input int n);
		tick(1);
		{i_btn_stop, i_btn_start, i_req_clear_total, i_req_defaults, i_req_timer_func} <= 5'(1 << k);
		tick(1);
		{i_btn_stop, i_btn_start, i_req_clear_total, i_req_defaults, i_req_timer_func} <= 5'h00;
		tick(n);
		@(negedge i_ref_clk);
	endtask : strobe
	task show(input logic [5:0] d);
		tick(1);
		i_dcfg <= d;
		tick(2);
		@(negedge i_ref_clk);
	endtask : show
	task conclude;
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		tick(3);
		i_rst_n <= 1'h1;
		sense(2'h2, 90); `CHK(o_level, 2'h3)
		sense(2'h2, 15); `CHK(o_level, 2'h2)
		mid <= 2'h1;
		sense(2'h3, 200); `CHK(o_level, 2'h2)
		mid <= 2'h0;
		sense(2'h1, 7900); `CHK(o_level, 2'h3)
		sense(2'h1, 150); `CHK(o_level, 2'h1)
		i_cfg_b <= i_cfg_a;
		i_set_time_zero <= 1'h0;
		for (int m = 0; m < 4; m++) begin
			tick(1);
			i_mode <= tissc_pkg::tissc_mode_t'(m);
			sense(seq[m][0], 110);
			sense(seq[m][1], 110); `CHK(o_running, 1'h1)
			sense(seq[m][2], 110); `CHK(o_running, 1'h0)
		end
		tick(1);
		i_mode <= tissc_pkg::mode_local;
		sense(2'h0, 110); `CHK(o_running, 1'h0)
		strobe(3, 3); `CHK(o_running, 1'h1)
		strobe(4, 3); `CHK(o_running, 1'h0)
		i_set_time_zero <= 1'h1;
		strobe(3, 3); `CHK(o_running, 1'h0)
		show(6'h10); `CHK(o_disp, tissc_pkg::show_set_time)
		show(6'h00); `CHK(o_disp, tissc_pkg::show_blank)
		show(6'h32); `CHK(o_disp, tissc_pkg::show_delay)
		show(6'h30); `CHK(o_show_total, 1'h1)
		show(6'h34); `CHK(o_show_total, 1'h0)
		show(6'h31); `CHK(o_show_tag, 1'h1)
		tick(1);
		i_out1_settings <= 8'hA5;
		{i_btn_program, i_btn_enter, i_prompt_shown} <= 3'h7;
		tick(2);
		@(negedge i_ref_clk);
		`CHK(o_out2_settings, 8'hA5)
		`CHK(o_config_menu, 1'h1)
		`CHK(o_display_mode, 1'h0)
		tick(1);
		{i_btn_program, i_btn_enter, i_prompt_shown} <= 3'h0;
		digits(16'h5E7A);
		strobe(0, 0); `CHK(o_timer_func, 1'h1)
		`CHK(o_display_mode, 1'h1)
		`CHK(o_config_menu, 1'h0)
		digits(16'h5E7B);
		strobe(1, 0); `CHK(o_restore_defaults, 1'h0)
		digits(16'h5E7A);
		strobe(1, 0); `CHK(o_restore_defaults, 1'h1)
		strobe(2, 0); `CHK(o_clear_lifetime_runtime, 1'h1)
		conclude();
	end
	// about four times the expected run length
	initial begin
		#2000000;
		errors++;
		conclude();
	end
endmodule : tissc_bench
